// ===== logic/armt_decode.sv
// ------------------------------------------------------------
// Window decoder: range, under and over codes per input
// ------------------------------------------------------------
module armt_decode
	import armt_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_ce,
	input  wire logic [7:0] i_window,
	input  wire logic       i_enable,
	output logic            o_range,
	output logic [2:0]      o_under,
	output logic [2:0]      o_over,
	output logic            o_active
);

	// Bit 7 is deliberately not looked at, so it cannot change monitoring.
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_range  <= 1'b0;
			o_under  <= 3'h0;
			o_over   <= 3'h0;
			o_active <= 1'b0;
		end
		else if (i_ce)
		begin
			o_range  <= i_window[RANGE_BIT];               // [R1] [R8] [R10]
			o_under  <= i_window[UNDER_MSB:UNDER_LSB];     // [R2]
			o_over   <= i_window[OVER_MSB:OVER_LSB];       // [R3]
			o_active <= i_enable;                          // [R9]
		end
	end

endmodule : armt_decode

// ===== logic/armt_pkg.sv
// Contract
// R1: Window bit 6 selects low or extended range.
// R2: Bits 5:3 hold the under-voltage offset code.
// R3: Bits 2:0 hold the over-voltage offset code.
// R4: Eight-bit level register sets nominal power-good level.
// R5: Second window register at 0x2F, resets 0x00.
// R6: Level registers at 0x2E and 0x30, reset 0x00.
// R7: All fields load defaults from non-volatile memory.
// R8: Second input's extended values follow its own range bit.
// R9: Comparators act only while their enable bit is set.
// R10: Window bit 7 reserved, reads back, no effect.
package armt_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] MON_A_WINDOW_OFFSET = 8'h2D;
	localparam logic [7:0] MON_A_LEVEL_OFFSET  = 8'h2E;
	localparam logic [7:0] MON_B_WINDOW_OFFSET = 8'h2F;
	localparam logic [7:0] MON_B_LEVEL_OFFSET  = 8'h30;
	localparam logic [7:0] REG_RESET_VALUE     = 8'h00;

	// ------------------------------------------------------------
	// Window field layout
	// ------------------------------------------------------------
	localparam int RSVD_BIT   = 7;
	localparam int RANGE_BIT  = 6;
	localparam int UNDER_MSB  = 5;
	localparam int UNDER_LSB  = 3;
	localparam int OVER_MSB   = 2;
	localparam int OVER_LSB   = 0;

	// Register count constant of 3; four registers are loaded from non-volatile memory after reset.
	localparam logic [1:0] NVM_REG_COUNT = 2'h3;

	typedef enum logic [1:0] {
		ARMT_LOAD,
		ARMT_RUN
	} armt_state_type;

endpackage : armt_pkg

// ===== logic/armt_regs.sv
// ------------------------------------------------------------
// Threshold register bank for two auxiliary monitor inputs
// ------------------------------------------------------------
module armt_regs
	import armt_pkg::*;
(
	input  wire logic       I_CORE_CLK,
	input  wire logic       I_NRST,
	input  wire logic       i_CE,
	input  wire logic       i_WR_EN,
	input  wire logic       i_RD_EN,
	input  wire logic [7:0] i_ADDR,
	input  wire logic [7:0] i_WDATA,
	input  wire logic [7:0] i_NVM_A_WINDOW,
	input  wire logic [7:0] i_NVM_A_LEVEL,
	input  wire logic [7:0] i_NVM_B_WINDOW,
	input  wire logic [7:0] i_NVM_B_LEVEL,
	input  wire logic       i_MON_A_COMPARATOR_ENABLE,
	input  wire logic       i_MON_B_COMPARATOR_ENABLE,
	output logic [7:0]      o_RDATA,
	output logic            o_RVALID,
	output logic            o_LOAD_DONE,
	output logic            o_MON_A_RANGE_SEL,
	output logic [2:0]      o_MON_A_UNDER_THRESH,
	output logic [2:0]      o_MON_A_OVER_THRESH,
	output logic [7:0]      o_MON_A_NOMINAL_LEVEL,
	output logic            o_MON_A_ACTIVE,
	output logic            o_MON_B_RANGE_SEL,
	output logic [2:0]      o_MON_B_UNDER_THRESH,
	output logic [2:0]      o_MON_B_OVER_THRESH,
	output logic [7:0]      o_MON_B_NOMINAL_LEVEL,
	output logic            o_MON_B_ACTIVE
);

	// ------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------
	logic [7:0]     mon_a_window;
	logic [7:0]     mon_a_level;
	logic [7:0]     mon_b_window;
	logic [7:0]     mon_b_level;
	armt_state_type state;
	logic [1:0]     en_sync;

	// Register read mux: offset to stored byte, zero for any unmapped offset.
	function automatic logic [7:0] read_mux(input logic [7:0] addr,
		input logic [7:0] wa, input logic [7:0] la,
		input logic [7:0] wb, input logic [7:0] lb);
		case (addr)
			MON_A_WINDOW_OFFSET: read_mux = wa;
			MON_A_LEVEL_OFFSET:  read_mux = la;
			MON_B_WINDOW_OFFSET: read_mux = wb;
			MON_B_LEVEL_OFFSET:  read_mux = lb;
			default:             read_mux = 8'h00;
		endcase
	endfunction : read_mux

	// ------------------------------------------------------------
	// Enable bits arrive from another block's pins; synchronise them
	// ------------------------------------------------------------
	armt_sync #(.WIDTH(2)) u_en_sync (
		.i_clk   (I_CORE_CLK),
		.i_nrst  (I_NRST),
		.i_ce    (i_CE),
		.i_async ({i_MON_B_COMPARATOR_ENABLE, i_MON_A_COMPARATOR_ENABLE}),
		.o_sync  (en_sync)
	);

	// Defaults are loaded one cycle after reset release, because the
	// asynchronous reset itself may only impose constants.
	always_ff @(posedge I_CORE_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			state <= ARMT_LOAD;
		else if (i_CE)
		begin
			case (state)
				ARMT_LOAD: state <= ARMT_RUN;
				ARMT_RUN:  state <= ARMT_RUN;
				default:   state <= ARMT_LOAD;
			endcase
		end
	end

	// Register writes; a write during the load cycle is overridden by defaults.
	always_ff @(posedge I_CORE_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			mon_a_window <= REG_RESET_VALUE;
			mon_a_level  <= REG_RESET_VALUE;                 // [R6]
			mon_b_window <= REG_RESET_VALUE;                 // [R5]
			mon_b_level  <= REG_RESET_VALUE;                 // [R6]
		end
		else if (i_CE)
		begin
			if (state == ARMT_LOAD)
			begin
				mon_a_window <= i_NVM_A_WINDOW;              // [R7]
				mon_a_level  <= i_NVM_A_LEVEL;               // [R7]
				mon_b_window <= i_NVM_B_WINDOW;              // [R7]
				mon_b_level  <= i_NVM_B_LEVEL;               // [R7]
			end
			else if (i_WR_EN)
			begin
				// All eight bits stored, reserved bit 7 included.
				case (i_ADDR)
					MON_A_WINDOW_OFFSET: mon_a_window <= i_WDATA;  // [R10]
					MON_A_LEVEL_OFFSET:  mon_a_level  <= i_WDATA;  // [R4] [R6]
					MON_B_WINDOW_OFFSET: mon_b_window <= i_WDATA;  // [R5]
					MON_B_LEVEL_OFFSET:  mon_b_level  <= i_WDATA;  // [R4] [R6]
					default:             ;
				endcase
			end
		end
	end

	// Read path: data registered, one cycle after the read strobe.
	always_ff @(posedge I_CORE_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			o_RDATA  <= 8'h00;
			o_RVALID <= 1'b0;
		end
		else if (i_CE)
		begin
			o_RVALID <= i_RD_EN;
			if (i_RD_EN)
				o_RDATA <= read_mux(i_ADDR, mon_a_window, mon_a_level,
					mon_b_window, mon_b_level);
		end
	end

	// Nominal levels and load status go straight out of registers.
	always_ff @(posedge I_CORE_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			o_MON_A_NOMINAL_LEVEL <= 8'h00;
			o_MON_B_NOMINAL_LEVEL <= 8'h00;
			o_LOAD_DONE           <= 1'b0;
		end
		else if (i_CE)
		begin
			o_MON_A_NOMINAL_LEVEL <= mon_a_level;            // [R4]
			o_MON_B_NOMINAL_LEVEL <= mon_b_level;            // [R4]
			o_LOAD_DONE           <= (state == ARMT_RUN);
		end
	end

	// ------------------------------------------------------------
	// Per-input window decode
	// ------------------------------------------------------------
	armt_decode u_dec_a (
		.i_clk    (I_CORE_CLK),
		.i_nrst   (I_NRST),
		.i_ce     (i_CE),
		.i_window (mon_a_window),
		.i_enable (en_sync[0]),
		.o_range  (o_MON_A_RANGE_SEL),
		.o_under  (o_MON_A_UNDER_THRESH),
		.o_over   (o_MON_A_OVER_THRESH),
		.o_active (o_MON_A_ACTIVE)
	);

	armt_decode u_dec_b (
		.i_clk    (I_CORE_CLK),
		.i_nrst   (I_NRST),
		.i_ce     (i_CE),
		.i_window (mon_b_window),
		.i_enable (en_sync[1]),
		.o_range  (o_MON_B_RANGE_SEL),
		.o_under  (o_MON_B_UNDER_THRESH),
		.o_over   (o_MON_B_OVER_THRESH),
		.o_active (o_MON_B_ACTIVE)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_range_a;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && $past(i_CE) && state == ARMT_RUN && $past(state) == ARMT_RUN
		|-> o_MON_A_RANGE_SEL == $past(mon_a_window[RANGE_BIT]);
	endproperty
	a_range_a: assert property (p_range_a) else $error("range A wrong"); // [R1]

	property p_under_b;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && $past(i_CE) && $past(state) == ARMT_RUN
		|-> o_MON_B_UNDER_THRESH == $past(mon_b_window[UNDER_MSB:UNDER_LSB]);
	endproperty
	a_under_b: assert property (p_under_b) else $error("under B wrong"); // [R2]

	property p_over_a;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && $past(i_CE) && $past(state) == ARMT_RUN
		|-> o_MON_A_OVER_THRESH == $past(mon_a_window[OVER_MSB:OVER_LSB]);
	endproperty
	a_over_a: assert property (p_over_a) else $error("over A wrong"); // [R3]

	property p_level_wr;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && state == ARMT_RUN && i_WR_EN && i_ADDR == MON_A_LEVEL_OFFSET ##1 i_CE
		|=> o_MON_A_NOMINAL_LEVEL == $past(i_WDATA, 2);
	endproperty
	a_level_wr: assert property (p_level_wr) else $error("level A lost"); // [R4]

	property p_b_window_rd;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && i_RD_EN && i_ADDR == MON_B_WINDOW_OFFSET
		|=> o_RVALID && o_RDATA == $past(mon_b_window);
	endproperty
	a_b_window_rd: assert property (p_b_window_rd) else $error("read B window"); // [R5]

	property p_nvm_load;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && state == ARMT_LOAD
		|=> mon_b_level == $past(i_NVM_B_LEVEL) && mon_a_window == $past(i_NVM_A_WINDOW);
	endproperty
	a_nvm_load: assert property (p_nvm_load) else $error("defaults not loaded"); // [R7]

	property p_enable;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE [*4] |-> o_MON_B_ACTIVE == $past(i_MON_B_COMPARATOR_ENABLE, 3);
	endproperty
	a_enable: assert property (p_enable) else $error("enable B path"); // [R9]

	property p_rsvd;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && state == ARMT_RUN && i_WR_EN && i_ADDR == MON_A_WINDOW_OFFSET
		##1 i_CE && i_RD_EN && i_ADDR == MON_A_WINDOW_OFFSET && !i_WR_EN
		|=> o_RDATA[RSVD_BIT] == $past(i_WDATA[RSVD_BIT], 2);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit lost"); // [R10]

	property p_range_b;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && $past(i_CE) && $past(state) == ARMT_RUN
		|-> o_MON_B_RANGE_SEL == $past(mon_b_window[RANGE_BIT]);
	endproperty
	a_range_b: assert property (p_range_b) else $error("range B wrong"); // [R8]

	// The first input's under code follows its own window register.
	property p_under_a;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && $past(i_CE) && $past(state) == ARMT_RUN
		|-> o_MON_A_UNDER_THRESH == $past(mon_a_window[UNDER_MSB:UNDER_LSB]);
	endproperty
	a_under_a: assert property (p_under_a) else $error("under A wrong"); // [R2]

	// The second input's over code must never borrow the first input's field.
	property p_over_b;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && $past(i_CE) && $past(state) == ARMT_RUN
		|-> o_MON_B_OVER_THRESH == $past(mon_b_window[OVER_MSB:OVER_LSB]);
	endproperty
	a_over_b: assert property (p_over_b) else $error("over B wrong"); // [R3]

	// A level write reaches the nominal output two enabled edges later.
	property p_level_b_wr;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && state == ARMT_RUN && i_WR_EN && i_ADDR == MON_B_LEVEL_OFFSET ##1 i_CE
		|=> o_MON_B_NOMINAL_LEVEL == $past(i_WDATA, 2);
	endproperty
	a_level_b_wr: assert property (p_level_b_wr) else $error("level B lost"); // [R4]

	// Reset values are still in place while the load cycle is pending.
	property p_level_reset;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		state == ARMT_LOAD
		|-> mon_a_level == REG_RESET_VALUE && mon_b_level == REG_RESET_VALUE;
	endproperty
	a_level_reset: assert property (p_level_reset) else $error("level reset"); // [R6]

	property p_b_window_reset;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		state == ARMT_LOAD |-> mon_b_window == REG_RESET_VALUE;
	endproperty
	a_b_window_reset: assert property (p_b_window_reset) else $error("window B reset"); // [R5]

	// The first input's enable takes the same three-edge path as the second's.
	property p_enable_a;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE [*4] |-> o_MON_A_ACTIVE == $past(i_MON_A_COMPARATOR_ENABLE, 3);
	endproperty
	a_enable_a: assert property (p_enable_a) else $error("enable A path"); // [R9]

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	// Load, extended range, reserved bit, level read and both enables.
	c_write_b: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && i_WR_EN && i_ADDR == MON_B_WINDOW_OFFSET && i_WDATA[RANGE_BIT]);
	c_read_lvl: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && i_RD_EN && i_ADDR == MON_B_LEVEL_OFFSET);
	c_active: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
		o_MON_A_ACTIVE && o_MON_B_ACTIVE);
	c_load: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
		$rose(o_LOAD_DONE));
	c_rsvd_wr: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
		i_CE && i_WR_EN && i_ADDR == MON_A_WINDOW_OFFSET && i_WDATA[RSVD_BIT]);

endmodule : armt_regs

// ===== logic/armt_sync.sv
// ------------------------------------------------------------
// Two-stage synchroniser for pin-side levels
// ------------------------------------------------------------
module armt_sync
	import armt_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			meta   <= '0;
			o_sync <= '0;
		end
		else if (i_ce)
		begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule : armt_sync

// ===== tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import armt_pkg::*;

	// ----------------------------------------
	// Bench signals and the bank under test
	// ----------------------------------------
	logic       clk, nrst, ce, wr, rd, ena, enb, rvalid, done, ar, br, aact, bact;
	logic [7:0] addr, wdata, nwa, nla, nwb, nlb, rdata, alev, blev, rd_val;
	logic [2:0] au, ao, bu, bo;
	int         num_errors, checks_done;

	armt_regs dut_u (
		.I_CORE_CLK(clk), .I_NRST(nrst), .i_CE(ce), .i_WR_EN(wr), .i_RD_EN(rd),
		.i_ADDR(addr), .i_WDATA(wdata), .i_NVM_A_WINDOW(nwa), .i_NVM_A_LEVEL(nla),
		.i_NVM_B_WINDOW(nwb), .i_NVM_B_LEVEL(nlb), .i_MON_A_COMPARATOR_ENABLE(ena),
		.i_MON_B_COMPARATOR_ENABLE(enb), .o_RDATA(rdata), .o_RVALID(rvalid),
		.o_LOAD_DONE(done), .o_MON_A_RANGE_SEL(ar), .o_MON_A_UNDER_THRESH(au),
		.o_MON_A_OVER_THRESH(ao), .o_MON_A_NOMINAL_LEVEL(alev), .o_MON_A_ACTIVE(aact),
		.o_MON_B_RANGE_SEL(br), .o_MON_B_UNDER_THRESH(bu), .o_MON_B_OVER_THRESH(bo),
		.o_MON_B_NOMINAL_LEVEL(blev), .o_MON_B_ACTIVE(bact)
	);

	// Core clock, 20 ns period.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	// Every drive lands 1 ns after an edge, so no race with the sampling edge.
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Bounded wait on the read answer (sel=1) or on the load flag (sel=0).
	task automatic wait_flag(input bit sel);
		int n;
		n = 0;
		while ((sel ? rvalid : done) !== 1'b1 && n < 4)
		begin
			step(1);
			n++;
		end
		if ((sel ? rvalid : done) !== 1'b1)
		begin
			num_errors++;
			$display("MISMATCH t=%0t flag never rose", $time);
			final_report();
		end
	endtask : wait_flag

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		// An idle edge keeps the strobe from dropping and rising in one step.
		step(1);
	endtask : wr_reg

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		wait_flag(1'b1);
		rd_val = rdata;
		chk(rd_val, e, "read back");
		step(1);
		chk({7'h00, rvalid}, 8'h00, "valid pulse");
	endtask : chk_rd

	// Bit 7 is left out of the field image on purpose: it must not steer anything.
	task automatic chk_fields(input logic [7:0] wa, la, wb, lb);
		chk({1'b0, ar, au, ao}, {1'b0, wa[6:0]}, "A window");
		chk({1'b0, br, bu, bo}, {1'b0, wb[6:0]}, "B window");
		chk(alev, la, "A level");
		chk(blev, lb, "B level");
	endtask : chk_fields

	task automatic t_load;
		step(11);
		chk_fields(8'h00, 8'h00, 8'h00, 8'h00);
		nrst = 1'b1;
		wait_flag(1'b0);
		chk_fields(nwa, nla, nwb, nlb);
		chk_rd(MON_A_WINDOW_OFFSET, nwa);
		chk_rd(MON_A_LEVEL_OFFSET, nla);
		chk_rd(MON_B_WINDOW_OFFSET, nwb);
		chk_rd(MON_B_LEVEL_OFFSET, nlb);
		$display("t_load done");
	endtask : t_load

	// Every code of both fields, both range values and both bit 7 values.
	task automatic t_codes;
		logic [7:0] w;
		logic [7:0] l;
		for (int k = 0; k < 8; k++)
		begin
			w = {k[0], k[1], k[2:0], 3'(7 - k)};
			l = 8'(k * 33);
			wr_reg(MON_A_WINDOW_OFFSET, w);
			wr_reg(MON_A_LEVEL_OFFSET, l);
			wr_reg(MON_B_WINDOW_OFFSET, ~w);
			wr_reg(MON_B_LEVEL_OFFSET, ~l);
			step(1);
			chk_fields(w, l, ~w, ~l);
			chk_rd(MON_A_WINDOW_OFFSET, w);
			chk_rd(MON_B_WINDOW_OFFSET, ~w);
			chk_rd(MON_A_LEVEL_OFFSET, l);
			chk_rd(MON_B_LEVEL_OFFSET, ~l);
		end
		$display("t_codes done");
	endtask : t_codes

	// Neighbouring offsets and a frozen clock enable must leave the last loop image.
	task automatic t_refused;
		wr_reg(8'h2C, 8'h5A);
		wr_reg(8'h31, 8'hA5);
		ce = 1'b0;
		wr_reg(MON_A_LEVEL_OFFSET, 8'h00);
		ce = 1'b1;
		step(2);
		chk_fields(8'hF8, 8'hE7, 8'h07, 8'h18);
		chk_rd(8'h2C, 8'h00);
		chk_rd(8'h31, 8'h00);
		$display("t_refused done");
	endtask : t_refused

	// Write then read one offset on consecutive edges: bit 7 returns but steers nothing.
	task automatic t_b2b;
		addr = MON_A_WINDOW_OFFSET;
		wdata = 8'h80;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		chk({7'h00, rvalid}, 8'h01, "valid after read");
		chk(rdata, 8'h80, "read after write");
		chk({1'b0, ar, au, ao}, 8'h00, "bit 7 inert");
		step(1);
		$display("t_b2b done");
	endtask : t_b2b

	task automatic t_enable;
		ena = 1'b1;
		step(2);
		chk({6'h0, aact, bact}, 8'h00, "enable early");
		step(1);
		chk({6'h0, aact, bact}, 8'h02, "A enabled");
		ena = 1'b0;
		enb = 1'b1;
		step(3);
		chk({6'h0, aact, bact}, 8'h01, "B enabled");
		$display("t_enable done");
	endtask : t_enable

	// Main sequence: all inputs set at time zero, reset held for 12 cycles.
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		nrst = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		ena = 1'b0;
		enb = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		nwa = 8'hD5;
		nla = 8'h3C;
		nwb = 8'h6B;
		nlb = 8'hA7;
		step(1);
		t_load();
		t_codes();
		t_refused();
		t_b2b();
		t_enable();
		final_report();
	end
endmodule : tb
